// >>> logic/jmp_controller.sv
// Jog and move profile controller with an APB register slave.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "jmp_defs.svh"
module jmp_controller #(
	parameter int VW = 24
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic JOG_FWD,
	input wire logic JOG_REV,
	input wire logic [15:0] STAGE_ID,
	input wire logic [31:0] STAGE_SERIAL,
	output logic [31:0] POSITION,
	output logic [VW-1:0] SPEED,
	output logic DIR_FWD,
	output logic MOVING,
	output jmp_pkg::jmp_state_type STATE
);
	import jmp_pkg::*;

	// Distance in Q10 millimetres scaled to whole encoder counts.
	function automatic logic signed [31:0] to_counts(
		input logic signed [31:0] d, input logic [13:0] c);
		logic signed [46:0] p;
		p = d * $signed({1'b0, c});
		return p[`JMP_MM_FRAC+31:`JMP_MM_FRAC];
	endfunction

	// Register file.
	logic cont_mode, prof_stop;
	logic signed [31:0] target, step, backlash;
	logic [VW-1:0] move_vmax, move_acc, jog_vmax, jog_acc;
	logic [13:0] cpm;
	logic [15:0] stage_id;
	logic [31:0] stage_serial;
	logic id_taken;
	logic [4:0] startup_cnt;

	// Pin synchronisers.
	logic [1:0] fwd_sync, rev_sync;
	logic [15:0] id_meta, id_sync;
	logic [31:0] ser_meta, ser_sync;

	// Motion state.
	jmp_state_type state, next_state;
	logic signed [47:0] pos_q, next_pos_q;
	logic [VW-1:0] vel, next_vel;
	logic dir, next_dir;
	logic jog_src, next_jog_src;
	logic bl_pend, next_bl_pend;
	logic signed [31:0] seg_tgt, next_seg_tgt, fin_tgt, next_fin_tgt;

	// Bus decode.
	wire bus_wr = PSEL & PENABLE & PWRITE;
	wire [31:0] wdata = PWDATA;
	wire sel_ctrl = PADDR == `JMP_OFS_CTRL;
	wire sel_cmd = PADDR == `JMP_OFS_CMD;
	wire sel_tgt = PADDR == `JMP_OFS_TARGET;
	wire sel_step = PADDR == `JMP_OFS_STEP;
	wire sel_mvm = PADDR == `JMP_OFS_MOVE_VMAX;
	wire sel_mac = PADDR == `JMP_OFS_MOVE_ACC;
	wire sel_jvm = PADDR == `JMP_OFS_JOG_VMAX;
	wire sel_jac = PADDR == `JMP_OFS_JOG_ACC;
	wire sel_bl = PADDR == `JMP_OFS_BACKLASH;
	wire sel_cpm = PADDR == `JMP_OFS_CPM;
	wire sel_sts = PADDR == `JMP_OFS_STATUS;
	wire sel_pos = PADDR == `JMP_OFS_POSITION;
	wire sel_id = PADDR == `JMP_OFS_STAGE_ID;
	wire sel_ser = PADDR == `JMP_OFS_SERIAL;
	wire sel_rw = sel_ctrl | sel_cmd | sel_tgt | sel_step | sel_mvm |
		sel_mac | sel_jvm | sel_jac | sel_bl | sel_cpm;
	wire sel_ro = sel_sts | sel_pos | sel_id | sel_ser;
	wire cpm_ok = wdata >= `JMP_CPM_MIN && wdata <= `JMP_CPM_MAX;
	wire bad_wr = PWRITE & (sel_ro | (sel_cpm & ~cpm_ok));
	wire cmd_abs = bus_wr & sel_cmd & wdata[`JMP_CMD_ABS];
	wire cmd_rel = bus_wr & sel_cmd & wdata[`JMP_CMD_REL];
	wire cmd_stop = bus_wr & sel_cmd & wdata[`JMP_CMD_STOP];

	// Zero-wait slave; unmapped or forbidden accesses flag an error.
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & (~(sel_rw | sel_ro) | bad_wr);
	wire [31:0] read_mux = ~(PSEL & ~PWRITE) ? 32'h0000_0000 :
		sel_ctrl ? {30'h0, prof_stop, cont_mode} :
		sel_tgt ? target :
		sel_step ? step :
		sel_mvm ? 32'(move_vmax) :
		sel_mac ? 32'(move_acc) :
		sel_jvm ? 32'(jog_vmax) :
		sel_jac ? 32'(jog_acc) :
		sel_bl ? backlash :
		sel_cpm ? {18'h0, cpm} :
		sel_sts ? {27'h0, bl_pend, MOVING, dir, state} :
		sel_pos ? POSITION :
		sel_id ? {16'h0, stage_id} :
		sel_ser ? stage_serial : 32'h0000_0000;

	// Read data is taken in the setup cycle, so it stands through access.
	always_ff @(posedge CLK) begin
		if (SRST) PRDATA <= 32'h0000_0000;
		else PRDATA <= read_mux;
	end

	// Register writes; identity registers have no write path.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cont_mode <= 1'b0;
			prof_stop <= 1'b1;
			target <= 32'h0000_0000;
			step <= `JMP_STEP_RST;
			move_vmax <= VW'(`JMP_VMAX_RST);
			move_acc <= VW'(`JMP_ACC_RST);
			jog_vmax <= VW'(`JMP_VMAX_RST);
			jog_acc <= VW'(`JMP_ACC_RST);
			backlash <= 32'h0000_0000;
			cpm <= `JMP_CPM_RST;
		end else if (bus_wr) begin
			if (sel_ctrl) begin
				cont_mode <= wdata[`JMP_CTRL_CONT];
				prof_stop <= wdata[`JMP_CTRL_PROF];
			end
			if (sel_tgt) target <= wdata;
			if (sel_step) step <= wdata;
			if (sel_mvm) move_vmax <= wdata[VW-1:0];
			if (sel_mac) move_acc <= wdata[VW-1:0];
			if (sel_jvm) jog_vmax <= wdata[VW-1:0];
			if (sel_jac) jog_acc <= wdata[VW-1:0];
			if (sel_bl) backlash <= wdata;
			if (sel_cpm && cpm_ok) cpm <= wdata[13:0];
		end
	end

	// Two-flop synchronisers for every pin input.
	always_ff @(posedge CLK) begin
		fwd_sync <= {fwd_sync[0], JOG_FWD};
		rev_sync <= {rev_sync[0], JOG_REV};
		id_meta <= STAGE_ID;
		id_sync <= id_meta;
		ser_meta <= STAGE_SERIAL;
		ser_sync <= ser_meta;
	end

	// Stage identity is captured once, a settling time after reset.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			startup_cnt <= 5'h00;
			id_taken <= 1'b0;
			stage_id <= 16'h0000;
			stage_serial <= 32'h0000_0000;
		end else if (!id_taken) begin
			startup_cnt <= startup_cnt + 5'h01;
			if (startup_cnt == `JMP_STARTUP_CYC) begin
				id_taken <= 1'b1;
				stage_id <= id_sync;
				stage_serial <= ser_sync;
			end
		end
	end

	// Jog demand and distance scaling.
	wire jog_f = fwd_sync[1] & ~rev_sync[1];
	wire jog_r = rev_sync[1] & ~fwd_sync[1];
	wire jog_any = jog_f | jog_r;
	wire signed [31:0] pos_int = pos_q[47:16];
	wire signed [31:0] bl_cnt = backlash[31] ? 32'sh0 :
		to_counts(backlash, cpm);
	wire signed [31:0] step_cnt = to_counts(step, cpm);
	wire signed [31:0] tgt_cnt = to_counts(target, cpm);
	wire signed [31:0] rel_dest = pos_int + tgt_cnt;
	wire signed [31:0] jog_dest = jog_f ? pos_int + step_cnt :
		pos_int - step_cnt;
	wire signed [31:0] start_dest = cmd_abs ? tgt_cnt :
		cmd_rel ? rel_dest : jog_dest;
	wire start_move = cmd_abs | cmd_rel;
	wire start_step = jog_any & ~cont_mode & ~start_move;

	// Reverse approaches overshoot below the target and return forward.
	wire need_bl = start_dest < pos_int && bl_cnt > 32'sh0;
	wire signed [31:0] start_seg = need_bl ? start_dest - bl_cnt :
		start_dest;

	// Profile arithmetic for the current segment.
	wire [VW-1:0] vmax = jog_src ? jog_vmax : move_vmax;
	wire [VW-1:0] acc = jog_src ? jog_acc : move_acc;
	wire signed [31:0] diff = dir ? seg_tgt - pos_int : pos_int - seg_tgt;
	wire [31:0] rem = diff[31] ? 32'h0 : diff;
	wire [95:0] brake_lhs = {48'h0, rem, 16'h0} * {71'h0, acc, 1'b0};
	wire [95:0] brake_rhs = {48'h0, 48'(vel) * 48'(vel)};
	wire braking = brake_lhs <= brake_rhs;
	wire arrive = {16'h0, rem, 16'h0} <= 64'(vel) + 64'(acc);
	wire [VW-1:0] vel_up = (vmax - vel < acc) ? vmax : vel + acc;
	wire [VW-1:0] vel_dn = (vel < acc) ? {VW{1'b0}} : vel - acc;
	wire signed [47:0] seg_q = {seg_tgt, 16'h0};
	wire signed [47:0] vel_q = 48'(vel);

	// Next-state logic of the profile generator.
	always_comb begin
		next_state = state;
		next_vel = vel;
		next_dir = dir;
		next_jog_src = jog_src;
		next_bl_pend = bl_pend;
		next_seg_tgt = seg_tgt;
		next_fin_tgt = fin_tgt;
		next_pos_q = dir ? pos_q + vel_q : pos_q - vel_q;
		unique case (state)
			JMP_IDLE: begin
				next_vel = {VW{1'b0}};
				next_pos_q = pos_q;
				if (start_move | start_step) begin
					next_state = JMP_MOVE;
					next_jog_src = start_step;
					next_fin_tgt = start_dest;
					next_seg_tgt = start_seg;
					next_bl_pend = need_bl;
					next_dir = start_seg >= pos_int;
				end else if (jog_any) begin
					next_state = JMP_JOG;
					next_jog_src = 1'b1;
					next_dir = jog_f;
				end
			end
			JMP_MOVE: begin
				if (cmd_stop) begin
					next_state = prof_stop ? JMP_HALT : JMP_IDLE;
					next_vel = prof_stop ? vel : {VW{1'b0}};
					next_bl_pend = 1'b0;
				end else if (arrive) begin
					next_pos_q = seg_q;
					next_vel = {VW{1'b0}};
					if (bl_pend) begin
						next_bl_pend = 1'b0;
						next_seg_tgt = fin_tgt;
						next_dir = 1'b1;
					end else begin
						next_state = JMP_IDLE;
					end
				end else if (braking) begin
					next_vel = vel_dn;
				end else begin
					next_vel = vel_up;
				end
			end
			JMP_JOG: begin
				if (jog_any && (jog_f == dir) && !cmd_stop) begin
					next_vel = vel_up;
				end else if (prof_stop) begin
					next_state = JMP_HALT;
					next_vel = vel_dn;
				end else begin
					next_state = JMP_IDLE;
					next_vel = {VW{1'b0}};
				end
			end
			JMP_HALT: begin
				next_vel = vel_dn;
				if (vel_dn == {VW{1'b0}}) next_state = JMP_IDLE;
			end
		endcase
	end

	// Motion registers.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state <= JMP_IDLE;
			pos_q <= 48'sh0;
			vel <= {VW{1'b0}};
			dir <= 1'b1;
			jog_src <= 1'b0;
			bl_pend <= 1'b0;
			seg_tgt <= 32'sh0;
			fin_tgt <= 32'sh0;
		end else begin
			state <= next_state;
			pos_q <= next_pos_q;
			vel <= next_vel;
			dir <= next_dir;
			jog_src <= next_jog_src;
			bl_pend <= next_bl_pend;
			seg_tgt <= next_seg_tgt;
			fin_tgt <= next_fin_tgt;
		end
	end

	// Outputs to the servo stage come straight from the motion registers.
	assign POSITION = pos_q[47:16];
	assign SPEED = vel;
	assign DIR_FWD = dir;
	assign MOVING = state != JMP_IDLE;
	assign STATE = state;
endmodule // jmp_controller
`default_nettype wire

// >>> logic/jmp_defs.svh
// Register offsets, field positions, reset values and limits of the jog and move controller.
`ifndef JMP_DEFS_SVH
`define JMP_DEFS_SVH
`define JMP_OFS_CTRL 12'h000
`define JMP_OFS_CMD 12'h004
`define JMP_OFS_TARGET 12'h008
`define JMP_OFS_STEP 12'h00C
`define JMP_OFS_MOVE_VMAX 12'h010
`define JMP_OFS_MOVE_ACC 12'h014
`define JMP_OFS_JOG_VMAX 12'h018
`define JMP_OFS_JOG_ACC 12'h01C
`define JMP_OFS_BACKLASH 12'h020
`define JMP_OFS_CPM 12'h024
`define JMP_OFS_STATUS 12'h028
`define JMP_OFS_POSITION 12'h02C
`define JMP_OFS_STAGE_ID 12'h030
`define JMP_OFS_SERIAL 12'h034
`define JMP_CTRL_CONT 0
`define JMP_CTRL_PROF 1
`define JMP_CMD_ABS 0
`define JMP_CMD_REL 1
`define JMP_CMD_STOP 2
`define JMP_CPM_MIN 32'h0000_0001
`define JMP_CPM_MAX 32'h0000_2710
`define JMP_CPM_RST 14'h07D0
`define JMP_STEP_RST 32'h0000_0200
`define JMP_VMAX_RST 24'h01_0000
`define JMP_ACC_RST 24'h00_0100
`define JMP_MM_FRAC 10
`define JMP_VEL_FRAC 16
`define JMP_STARTUP_CYC 5'h10
`endif

// >>> logic/jmp_pkg.sv
// Types shared by the jog and move controller.
`default_nettype none
package jmp_pkg;
	typedef enum logic [1:0] {
		JMP_IDLE = 2'b00,
		JMP_MOVE = 2'b01,
		JMP_JOG = 2'b10,
		JMP_HALT = 2'b11
	} jmp_state_type;
endpackage
`default_nettype wire

// >>> testbench/jmp_checker.sv
// Port checker for the jog and move controller.
`timescale 1ns/1ps
`default_nettype none
module jmp_checker
	import jmp_pkg::*;
#(
	parameter int VW = 24
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic PSLVERR,
	input wire logic [31:0] POSITION,
	input wire logic [VW-1:0] SPEED,
	input var jmp_pkg::jmp_state_type STATE
);
	logic wr;
	logic cpm_wr;
	logic cpm_ok;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);
	// Writes in their access phase, and the legal scale range.
	assign wr = PSEL && PENABLE && PWRITE;
	assign cpm_wr = wr && PADDR == 12'h024;
	assign cpm_ok = PWDATA >= 32'h1 && PWDATA <= 32'h2710;
	// Refusals and acceptance of writes, then motion relations across cycles.
	ro_write_a: assert property (wr && PADDR >= 12'h028 |-> PSLVERR)
		else $error("read-only write accepted");
	cpm_refuse_a: assert property (cpm_wr && !cpm_ok |-> PSLVERR)
		else $error("scale out of range accepted");
	cpm_accept_a: assert property (cpm_wr && cpm_ok |-> !PSLVERR)
		else $error("legal scale refused");
	idle_hold_a: assert property (STATE == JMP_IDLE &&
		$past(STATE) == JMP_IDLE |-> SPEED == 0 && $stable(POSITION))
		else $error("axis drifts while idle");
	halt_slows_a: assert property (STATE == JMP_HALT |=>
		SPEED <= $past(SPEED)) else $error("speed rises while halting");
	halt_ends_a: assert property ($rose(STATE == JMP_HALT) |->
		##[1:1000] STATE == JMP_IDLE) else $error("halt never ends");
	jog_hold_a: assert property (STATE == JMP_JOG &&
		$past(STATE) == JMP_JOG |-> SPEED >= $past(SPEED))
		else $error("speed drops while jogging");
	start_rest_a: assert property (STATE != JMP_IDLE &&
		$past(STATE) == JMP_IDLE |-> SPEED == 0)
		else $error("motion starts with a speed jump");
endmodule // jmp_checker
bind jmp_controller jmp_checker #(.VW(VW)) CHK (.CLK(CLK), .SRST(SRST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PWDATA(PWDATA), .PSLVERR(PSLVERR), .POSITION(POSITION),
	.SPEED(SPEED), .STATE(STATE));
`default_nettype wire

// >>> testbench/jmp_stage.sv
// Stage model: identity straps and an encoder following the axis.
`timescale 1ns/1ps
`default_nettype none
module jmp_stage #(
	parameter logic [15:0] ID = 16'h00A5, // Arbitrary value.
	parameter logic [31:0] SN = 32'h0000_1234 // Arbitrary value.
) (
	input wire logic clk,
	input wire logic [31:0] pos,
	output logic [15:0] id,
	output logic [31:0] sn,
	output logic last_fwd
);
	logic [31:0] seen;
	// The straps never change, so the captured identity is fixed.
	assign id = ID;
	assign sn = SN;
	// The encoder notes which way the axis last moved.
	always @(posedge clk) begin
		if (pos !== seen) begin
			last_fwd <= $signed(pos) > $signed(seen);
			seen <= pos;
		end
	end
endmodule // jmp_stage
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the jog and move controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import jmp_pkg::*;
	logic CLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic JOG_FWD = 0, JOG_REV = 0, PREADY, PSLVERR, fwd, err;
	logic DIR_FWD, MOVING;
	logic [11:0] PADDR = '0;
	logic [31:0] PWDATA = '0, PRDATA, POSITION, STAGE_SERIAL, rd;
	logic [23:0] SPEED, prev;
	logic [15:0] STAGE_ID;
	jmp_state_type STATE, pst;
	int bad_count = 0, comparisons = 0, seed = 31078;
	int lo, pk, flat, dec, starts, t, i;
	int cpmv[4] = '{0, 10001, 10000, 1};
	int blv[3] = '{50, 0, -5};
	jmp_controller DUT (.CLK(CLK), .SRST(SRST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.DIR_FWD(DIR_FWD),
		.JOG_FWD(JOG_FWD), .JOG_REV(JOG_REV), .STAGE_ID(STAGE_ID),
		.STAGE_SERIAL(STAGE_SERIAL), .POSITION(POSITION), .SPEED(SPEED),
		.MOVING(MOVING), .STATE(STATE));
	jmp_stage STG (.clk(CLK), .pos(POSITION), .id(STAGE_ID),
		.sn(STAGE_SERIAL), .last_fwd(fwd));
	// Clock of 4 ns period.
	always #2 CLK = ~CLK;
	// Record lowest position, peak speed, plateaus, braking step, starts.
	always @(posedge CLK) begin
		if ($signed(POSITION) < lo) lo = $signed(POSITION);
		if (SPEED > pk) pk = SPEED;
		if (STATE == JMP_MOVE && SPEED != 0 && SPEED == prev) flat++;
		if (STATE == JMP_HALT && pst == JMP_HALT && SPEED != 0)
			dec = prev - SPEED;
		if (STATE == JMP_MOVE && pst != JMP_MOVE) starts++;
		prev = SPEED;
		pst = STATE;
	end
	// Compare a value seen with the one expected.
	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Print the counts and the verdict, then stop.
	task automatic finish_test();
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// One bus transfer; read data and error are taken when ready is seen.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge CLK);
			if (PREADY === 1'b1) break;
		end
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (n == 20) bad_count++;
		if (n == 20) finish_test();
	endtask
	// Wait, with a limit, for the axis to come to rest.
	task automatic wait_idle();
		int n = 0;
		repeat (4) @(posedge CLK);
		while (STATE !== JMP_IDLE && n < 5000) begin
			@(posedge CLK);
			n++;
		end
		if (n == 5000) bad_count++;
		if (n == 5000) finish_test();
	endtask
	// Load the target, issue a command and let it finish.
	task automatic move(input logic [31:0] cmd, tgt);
		apb(1, 12'h008, tgt);
		lo = $signed(POSITION);
		pk = 0;
		flat = 0;
		apb(1, 12'h004, cmd);
		wait_idle();
	endtask
	// Main sequence.
	initial begin
		repeat (10) @(posedge CLK);
		SRST <= 1'b0;
		apb(0, 12'h024, 0);
		chk("cpm reset", rd, 32'h7D0);
		foreach (cpmv[i]) begin
			apb(1, 12'h024, cpmv[i]);
			chk("cpm err", err, cpmv[i] < 1 || cpmv[i] > 10000);
		end
		apb(0, 12'h024, 0);
		chk("cpm kept", rd, 32'h1);
		for (i = 0; i < 2; i++) begin
			apb(1, 12'(48 + 4 * i), $random(seed));
			chk("id err", err, 1);
			apb(0, 12'(48 + 4 * i), 0);
			chk("id", rd, i ? STAGE_SERIAL : {16'h0, STAGE_ID});
		end
		apb(0, 12'h040, 0);
		chk("unmapped err", err, 1);
		chk("unmapped rd", rd, 0);
		apb(1, 12'h024, 32'd2000);
		for (i = 16; i < 32; i += 4)
			apb(1, 12'(i), i[2] ? 32'h1000 : 32'h40000);
		JOG_FWD <= 1'b1;
		repeat (4) @(posedge CLK);
		JOG_FWD <= 1'b0;
		wait_idle();
		chk("one step", POSITION, 32'd1000);
		starts = 0;
		JOG_REV <= 1'b1;
		for (t = 0; t < 5000 && starts < 3; t++) @(posedge CLK);
		if (t == 5000) bad_count++;
		if (t == 5000) finish_test();
		chk("rev dir", DIR_FWD, 0);
		chk("moving", MOVING, 1);
		JOG_REV <= 1'b0;
		wait_idle();
		chk("step count", starts, 3);
		chk("steps", POSITION, 32'(-2000));
		apb(1, 12'h000, 32'h3);
		JOG_FWD <= 1'b1;
		repeat (100) @(posedge CLK);
		chk("jog state", STATE, JMP_JOG);
		chk("jog speed", SPEED, 32'h40000);
		JOG_FWD <= 1'b0;
		wait_idle();
		chk("halt ramp", dec, 32'h1000);
		apb(1, 12'h000, 32'h1);
		JOG_REV <= 1'b1;
		repeat (100) @(posedge CLK);
		dec = 0;
		JOG_REV <= 1'b0;
		repeat (5) @(posedge CLK);
		chk("quick dec", dec, 0);
		chk("quick state", STATE, JMP_IDLE);
		chk("quick speed", SPEED, 0);
		chk("quick moving", MOVING, 0);
		apb(1, 12'h000, 32'h2);
		apb(1, 12'h024, 32'd1024);
		move(1, 0);
		chk("abs", POSITION, 0);
		move(2, 2000);
		chk("long", POSITION, 32'd2000);
		chk("peak", pk, 32'h40000);
		apb(0, 12'h02C, 0);
		chk("pos reg", rd, 32'd2000);
		apb(0, 12'h028, 0);
		chk("status", rd, 32'h4);
		apb(1, 12'h008, 32'd3000);
		apb(1, 12'h004, 32'h2);
		apb(1, 12'h004, 32'h4);
		@(posedge CLK);
		chk("stop halt", STATE, JMP_HALT);
		wait_idle();
		chk("stopped", POSITION, 32'd2000);
		move(2, 20);
		chk("short", POSITION, 32'd2020);
		chk("plateau", flat, 0);
		chk("below peak", pk < 32'h40000, 1);
		foreach (blv[i]) begin
			apb(1, 12'h020, blv[i]);
			t = 1500 - ($random(seed) & 32'h1FF);
			move(1, t);
			chk("target", POSITION, t);
			chk("overshoot", lo, t - (blv[i] > 0 ? blv[i] : 0));
			if (blv[i] > 0) chk("forward", fwd, 1);
			move(1, 2020);
		end
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
